// *** logic/rws_supervisor.sv ***
/*
  reset and supply supervisor: reset cause flags, reset sequencing, watchdog control,
  brown-out and low-voltage flags and interrupt flags, on a special function register port.
  assumes the core issues one-cycle sfr read and write strobes and that comparator
  outputs and the force-enable pin are asynchronous levels.
*/
`timescale 1ns/1ps
// Functional notes
// - any reset source pulses core reset and returns registers to defaults; cause and interrupt flags are kept, and power-on leaves CPU_RST low
// - power-on sets the top cause bit and clears all other cause bits
// - cause register resets to 80h, clears on read, low three bits read zero
// - reset pin held low over 2 us resets and sets cause bit 6
// - watchdog overflow resets and sets cause bit 5
// - brown-out reset sets cause bit 4
// - wake from deep sleep sets cause bit 3; listed wake sources
// - watchdog counts rc ticks and resets on overflow unless cleared first
// - force pin high enables watchdog; else soft enable, off clears counter
// - timeout codes 0xx give 500ms..4s, 1xx give 31.25ms..250ms
// - writing 0110 to the kick field clears the watchdog, others ignored
// - keep-alive zero at sleep entry clears the watchdog
// - keep-alive one keeps watchdog counting; overflow wakes and resets
// - in reset mode, supply below threshold resets and sets brown-out status
// - reset and status hold until supply passes threshold plus hysteresis
// - brown-out threshold select defaults to the 2.15 V setting
// - in interrupt mode each status change sets its flag and requests interrupt
// - brown-out wakes from sleep; reset wins over interrupt
// - low-voltage detector on while its power-down bit is zero
// - threshold codes 11xx pick the monitor pin, others pick supply levels
// - low-voltage interrupt needs global and local enable; change sets flag
// - writing one clears an interrupt flag
// - brown-out interrupt needs interrupt mode, global and local enable
// - two-bit brown-out select gives 2.15, 2.35, 2.55, 2.75 V settings
module rws_supervisor
  import rws_pkg::*;
#(
  parameter int RC_HZ = 32768
) (
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       EXT_RST_B,
  input  wire logic       WATCHDOG_FORCE_ENABLE_PIN,
  input  wire logic       WDOG_RC_TICK,
  input  wire logic       DEEP_SLEEP_MODE,
  input  wire logic [4:0] WAKE_SRC,
  input  wire logic       OSC_LOCK,
  input  wire logic       BROWNOUT_BELOW,
  input  wire logic       LOW_VOLTAGE_BELOW,
  input  wire logic       SUPERVISOR_GLOBAL_IRQ_ENABLE,
  output logic [7:0]      SFR_RDATA,
  output logic            CPU_RST,
  output logic            SUP_IRQ,
  output logic            BROWNOUT_ON,
  output logic [1:0]      BROWNOUT_THRESHOLD_SELECT,
  output logic            LOW_VOLTAGE_ON,
  output logic [3:0]      LOW_VOLTAGE_THRESHOLD_SELECT,
  output logic            MONITOR_PIN_SEL
);
  localparam int PIN_CYC = (`RWS_PIN_MIN_NS + `RWS_CLK_PERIOD_NS - 1) / `RWS_CLK_PERIOD_NS;

  rws_top_st_t s;
  rws_top_st_t next_s;
  rws_wdog_if  wif ();

  logic       wr_stat;
  logic       wr_clk;
  logic       wr_bcf;
  logic       wr_pd;
  logic       wr_ie;
  logic       wr_if;
  logic       wr_lv;
  logic       rd_cause;
  logic       sleeping;
  logic       bor_now;
  logic       lv_now;
  logic       bor_rst;
  logic       bor_irq_set;
  logic       lv_irq_set;
  logic       pin_low;
  logic       pin_rst;
  logic       wake;
  logic       hold_req;
  logic       wd_on;
  logic [7:0] set_vec;

  // power-on values of the whole state
  function automatic rws_top_st_t rws_por();
    rws_top_st_t r;
    r = '0;
    r.seq = RWS_RUN;
    r.cause = `RWS_RST_CAUSE;
    r.wdcfg = `RWS_RST_WDCFG;
    r.borcfg = `RWS_RST_BORCFG;
    r.pwrdn = `RWS_RST_PWRDN;
    r.lvcfg = `RWS_RST_LVCFG;
    r.bor_on = 1'b1; // detector powered while held in power-on reset
    r.lv_on = 1'b1;
    return r;
  endfunction : rws_por

  // sfr strobe decode
  assign wr_stat  = SFR_WR && SFR_ADDR == `RWS_ADR_STAT;
  assign wr_clk   = SFR_WR && SFR_ADDR == `RWS_ADR_WDCFG;
  assign wr_bcf   = SFR_WR && SFR_ADDR == `RWS_ADR_BORCFG;
  assign wr_pd    = SFR_WR && SFR_ADDR == `RWS_ADR_PWRDN;
  assign wr_ie    = SFR_WR && SFR_ADDR == `RWS_ADR_IRQEN;
  assign wr_if    = SFR_WR && SFR_ADDR == `RWS_ADR_IRQFLG;
  assign wr_lv    = SFR_WR && SFR_ADDR == `RWS_ADR_LVCFG;
  assign rd_cause = SFR_RD && SFR_ADDR == `RWS_ADR_CAUSE;

  // detector status and events
  assign sleeping = s.seq == RWS_SLEEP;
  assign bor_now  = !s.pwrdn[`RWS_PD_BOR] && (!sleeping || s.borcfg[`RWS_BCF_SLEEP_ON]) && s.bor_s[1];
  assign lv_now   = !s.pwrdn[`RWS_PD_LV] && s.lv_s[1];
  assign bor_rst  = s.borcfg[`RWS_BCF_RST_MODE] && bor_now;
  assign bor_irq_set = !s.borcfg[`RWS_BCF_RST_MODE] && SUPERVISOR_GLOBAL_IRQ_ENABLE
                       && s.irq_en[0] && (bor_now != s.bor_q);
  assign lv_irq_set  = SUPERVISOR_GLOBAL_IRQ_ENABLE && s.irq_en[1] && (lv_now != s.lv_q);
  assign pin_low  = !s.pin_s[1];
  assign pin_rst  = pin_low && s.pin_cnt == 8'(PIN_CYC);
  assign wake     = sleeping && ((|WAKE_SRC) || pin_low || wif.ovf || bor_rst || bor_irq_set);
  assign hold_req = pin_rst || wif.ovf || bor_rst || wake;
  assign wd_on    = s.frc_s[1] || s.wdcfg[`RWS_CLK_WDOG_EN];

  // cause bits raised this cycle
  always_comb begin
    set_vec = 8'h00;
    set_vec[`RWS_CAUSE_PIN] = pin_rst;
    set_vec[`RWS_CAUSE_WDOG] = wif.ovf;
    set_vec[`RWS_CAUSE_BOR] = bor_rst;
    set_vec[`RWS_CAUSE_WAKE] = wake;
  end

  // watchdog hookup
  assign wif.run  = s.wdt_run;
  assign wif.clr  = s.wdt_clr;
  assign wif.tick = WDOG_RC_TICK;
  assign wif.sel  = s.wdcfg[7:5];

  rws_wdog #(
    .RC_HZ(RC_HZ)
  ) u_wdog (
    .clk  (CLK),
    .rst_b(RST_B),
    .w    (wif.wdog)
  );

  // next state
  always_comb begin
    next_s = s;
    // synchronisers
    next_s.pin_s = {s.pin_s[0], EXT_RST_B};
    next_s.frc_s = {s.frc_s[0], WATCHDOG_FORCE_ENABLE_PIN};
    next_s.bor_s = {s.bor_s[0], BROWNOUT_BELOW};
    next_s.lv_s  = {s.lv_s[0], LOW_VOLTAGE_BELOW};
    // pin low-time counter, saturating
    if (!pin_low) begin
      next_s.pin_cnt = 8'h00;
    end else if (s.pin_cnt != 8'(PIN_CYC)) begin
      next_s.pin_cnt = s.pin_cnt + 8'h01;
    end
    // status flags follow the detectors
    next_s.bor_q = bor_now;
    next_s.lv_q = lv_now;
    // clear on read, a new cause wins
    next_s.cause = ((rd_cause ? 8'h00 : s.cause) | set_vec) & 8'hF8;
    // interrupt flags: write one clears, set wins
    next_s.irq_flag = (s.irq_flag & ~(wr_if ? SFR_WDATA[1:0] : 2'b00))
                      | {lv_irq_set, bor_irq_set};
    // configuration writes
    if (wr_clk) begin
      next_s.wdcfg = SFR_WDATA;
    end
    if (wr_bcf) begin
      next_s.borcfg = {SFR_WDATA[7:1], 1'b1};
    end
    if (wr_pd) begin
      next_s.pwrdn = {1'b0, SFR_WDATA[6:0]};
    end
    if (wr_ie) begin
      next_s.irq_en = SFR_WDATA[1:0];
    end
    if (wr_lv) begin
      next_s.lvcfg = {SFR_WDATA[7:4], 4'h0};
    end
    // reset sequencer
    case (s.seq)
      RWS_RUN: begin
        if (hold_req) begin
          next_s.seq = RWS_HOLD;
        end else if (DEEP_SLEEP_MODE) begin
          next_s.seq = RWS_SLEEP;
          next_s.keep = s.borcfg[`RWS_BCF_KEEP];
        end
      end
      RWS_SLEEP: begin
        if (hold_req) begin
          next_s.seq = RWS_HOLD;
        end else if (!DEEP_SLEEP_MODE) begin
          next_s.seq = RWS_RUN;
        end
      end
      RWS_HOLD: begin
        if (!hold_req && s.rst_cnt == 8'h00) begin
          next_s.seq = RWS_RUN;
          next_s.cpu_rst = 1'b0;
        end else if (!hold_req) begin
          next_s.rst_cnt = s.rst_cnt - 8'h01;
        end
      end
      default: begin
        next_s.seq = RWS_HOLD;
      end
    endcase
    // any reset source: core reset and default settings
    if (hold_req || s.seq == RWS_HOLD) begin
      next_s.seq = (hold_req || s.rst_cnt != 8'h00) ? RWS_HOLD : RWS_RUN;
      next_s.cpu_rst = next_s.seq == RWS_HOLD;
      next_s.wdcfg = `RWS_RST_WDCFG;
      next_s.borcfg = `RWS_RST_BORCFG;
      next_s.pwrdn = `RWS_RST_PWRDN;
      next_s.lvcfg = `RWS_RST_LVCFG;
      next_s.irq_en = 2'b00;
      next_s.keep = 1'b0;
      if (hold_req) begin
        next_s.rst_cnt = 8'(`RWS_RST_HOLD_CYC);
      end
    end
    // watchdog run and clear
    next_s.wdt_run = wd_on && (next_s.seq == RWS_RUN || (next_s.seq == RWS_SLEEP && next_s.keep));
    next_s.wdt_clr = !wd_on || next_s.seq == RWS_HOLD
                     || (next_s.seq == RWS_SLEEP && !next_s.keep)
                     || (wr_stat && SFR_WDATA[3:0] == `RWS_KICK_CODE);
    // read port
    if (SFR_RD) begin
      case (SFR_ADDR)
        `RWS_ADR_STAT:   next_s.rdata = {OSC_LOCK, s.bor_q, s.lv_q, 5'h00};
        `RWS_ADR_CAUSE:  next_s.rdata = {s.cause[7:3], 3'b000};
        `RWS_ADR_WDCFG:  next_s.rdata = s.wdcfg;
        `RWS_ADR_BORCFG: next_s.rdata = s.borcfg;
        `RWS_ADR_PWRDN:  next_s.rdata = s.pwrdn;
        `RWS_ADR_IRQEN:  next_s.rdata = {6'h00, s.irq_en};
        `RWS_ADR_IRQFLG: next_s.rdata = {6'h00, s.irq_flag};
        `RWS_ADR_LVCFG:  next_s.rdata = s.lvcfg;
        default:         next_s.rdata = 8'h00;
      endcase
    end
    // registered outputs
    next_s.irq = |next_s.irq_flag;
    next_s.bor_on = !next_s.pwrdn[`RWS_PD_BOR]
                    && (next_s.seq != RWS_SLEEP || next_s.borcfg[`RWS_BCF_SLEEP_ON]);
    next_s.bor_lvl = next_s.borcfg[3:2];
    next_s.lv_on = !next_s.pwrdn[`RWS_PD_LV];
    next_s.lv_lvl = next_s.lvcfg[7:4];
    next_s.lv_pin = next_s.lv_on && next_s.lvcfg[7:6] == 2'b11;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= rws_por();
    end else begin
      s <= next_s;
    end
  end

  // output drive straight from state
  assign SFR_RDATA                    = s.rdata;
  assign CPU_RST                      = s.cpu_rst;
  assign SUP_IRQ                      = s.irq;
  assign BROWNOUT_ON                  = s.bor_on;
  assign BROWNOUT_THRESHOLD_SELECT    = s.bor_lvl;
  assign LOW_VOLTAGE_ON               = s.lv_on;
  assign LOW_VOLTAGE_THRESHOLD_SELECT = s.lv_lvl;
  assign MONITOR_PIN_SEL              = s.lv_pin;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_reset_with(int b);
    CPU_RST && s.cause[b];
  endsequence

  property p_cause_clear;
    (rd_cause && set_vec == 8'h00) |=> s.cause == 8'h00;
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared by read");

  property p_cause_read;
    rd_cause |=> SFR_RDATA == {$past(s.cause[7:3]), 3'b000};
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("cause read value wrong");

  property p_pin_reset;
    pin_rst |=> s_reset_with(`RWS_CAUSE_PIN);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");

  property p_wdog_reset;
    wif.ovf |=> s_reset_with(`RWS_CAUSE_WDOG);
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog reset not taken");

  property p_bor_reset;
    bor_rst |=> s_reset_with(`RWS_CAUSE_BOR) ##0 s.bor_q;
  endproperty
  a_bor_reset: assert property (p_bor_reset) else $error("brown-out reset not taken");

  property p_kick;
    (wr_stat && SFR_WDATA[3:0] == `RWS_KICK_CODE) |=> s.wdt_clr;
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not clear watchdog");

  property p_bor_irq;
    bor_irq_set |=> s.irq_flag[0] && SUP_IRQ;
  endproperty
  a_bor_irq: assert property (p_bor_irq) else $error("brown-out interrupt not raised");

  property p_sleep_bor;
    (sleeping && bor_rst) |=> s_reset_with(`RWS_CAUSE_WAKE) ##0 !$rose(s.irq_flag[0]);
  endproperty
  a_sleep_bor: assert property (p_sleep_bor) else $error("sleep brown-out handling wrong");

  property p_defaults;
    $rose(CPU_RST) |-> s.wdcfg == `RWS_RST_WDCFG && s.borcfg == `RWS_RST_BORCFG && s.irq_en == 2'b00;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored on reset");

  property p_lv_off;
    s.pwrdn[`RWS_PD_LV] |-> !LOW_VOLTAGE_ON ##1 !$past(lv_now);
  endproperty
  a_lv_off: assert property (p_lv_off) else $error("low-voltage detector not off");

  // a disabled watchdog is held at zero
  property p_wdog_off;
    !wd_on |=> s.wdt_clr;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("disabled watchdog not held clear");
endmodule : rws_supervisor

// *** logic/rws_consts.svh ***
/*
  register offsets, field positions, reset values and timing figures of the reset and supply supervisor.
  assumes an 8-bit special function register space and a 100 MHz system clock.
*/
`ifndef RWS_CONSTS_SVH
`define RWS_CONSTS_SVH
// register offsets
`define RWS_ADR_STAT      8'hB6
`define RWS_ADR_CAUSE     8'hB7
`define RWS_ADR_BORCFG    8'hBC
`define RWS_ADR_WDCFG     8'hBD
`define RWS_ADR_PWRDN     8'hBF
`define RWS_ADR_IRQEN     8'hAC
`define RWS_ADR_IRQFLG    8'hB4
`define RWS_ADR_LVCFG     8'hB5
// field positions
`define RWS_CAUSE_POR     7
`define RWS_CAUSE_PIN     6
`define RWS_CAUSE_WDOG    5
`define RWS_CAUSE_BOR     4
`define RWS_CAUSE_WAKE    3
`define RWS_STAT_LOCK     7
`define RWS_STAT_BOR      6
`define RWS_STAT_LV       5
`define RWS_CLK_WDOG_EN   4
`define RWS_BCF_SLEEP_ON  5
`define RWS_BCF_RST_MODE  4
`define RWS_BCF_KEEP      1
`define RWS_PD_BOR        4
`define RWS_PD_LV         3
`define RWS_KICK_CODE     4'h6
// reset values
`define RWS_RST_CAUSE     8'h80
`define RWS_RST_WDCFG     8'h00
`define RWS_RST_BORCFG    8'h11
`define RWS_RST_PWRDN     8'h27
`define RWS_RST_LVCFG     8'h00
// timing
`define RWS_CLK_PERIOD_NS 10
`define RWS_PIN_MIN_NS    2000
`define RWS_RST_HOLD_CYC  16
`define RWS_WDOG_BASE_US  31250
`define RWS_US_PER_S      1000000
`define RWS_WDOG_CNT_W    24
`endif

// *** logic/rws_pkg.sv ***
/*
  types shared by the supervisor modules: sequencer states and state records.
  assumes rws_consts.svh is on the include path.
*/
`include "rws_consts.svh"
package rws_pkg;
  typedef enum logic [1:0] {
    RWS_RUN   = 2'b00,
    RWS_HOLD  = 2'b01,
    RWS_SLEEP = 2'b10
  } rws_seq_t;

  typedef struct packed {
    rws_seq_t   seq;
    logic [7:0] rst_cnt;
    logic [7:0] pin_cnt;
    logic [1:0] pin_s;
    logic [1:0] frc_s;
    logic [1:0] bor_s;
    logic [1:0] lv_s;
    logic       keep;
    logic       bor_q;
    logic       lv_q;
    logic [7:0] cause;
    logic [7:0] wdcfg;
    logic [7:0] borcfg;
    logic [7:0] pwrdn;
    logic [7:0] lvcfg;
    logic [1:0] irq_en;
    logic [1:0] irq_flag;
    logic [7:0] rdata;
    logic       cpu_rst;
    logic       irq;
    logic       bor_on;
    logic [1:0] bor_lvl;
    logic       lv_on;
    logic [3:0] lv_lvl;
    logic       lv_pin;
    logic       wdt_run;
    logic       wdt_clr;
  } rws_top_st_t;

  typedef struct packed {
    logic [`RWS_WDOG_CNT_W-1:0] cnt;
    logic                       ovf;
  } rws_wdog_st_t;
endpackage : rws_pkg

// *** logic/rws_wdog_if.sv ***
/*
  control and overflow signals between the supervisor core and its watchdog counter.
  assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface rws_wdog_if;
  logic       run;
  logic       clr;
  logic       tick;
  logic [2:0] sel;
  logic       ovf;
  modport ctl  (output run, output clr, output tick, output sel, input ovf);
  modport wdog (input run, input clr, input tick, input sel, output ovf);
endinterface : rws_wdog_if

// *** logic/rws_wdog.sv ***
/*
  watchdog counter advanced by the rc oscillator tick, with timeout select and overflow pulse.
  assumes tick is a one-cycle enable synchronous to clk.
*/
`timescale 1ns/1ps
module rws_wdog
  import rws_pkg::*;
#(
  parameter int RC_HZ = 32768
) (
  input wire logic clk,
  input wire logic rst_b,
  rws_wdog_if.wdog w
);
  localparam longint BASE = longint'(RC_HZ) * `RWS_WDOG_BASE_US / `RWS_US_PER_S;

  rws_wdog_st_t s;
  rws_wdog_st_t next_s;
  logic [`RWS_WDOG_CNT_W-1:0] lim;

  // timeout in rc ticks: 1xx short range, 0xx long range
  function automatic logic [`RWS_WDOG_CNT_W-1:0] rws_limit(input logic [2:0] sel);
    logic [2:0] sh;
    sh = sel[2] ? {1'b0, sel[1:0]} : {1'b1, sel[1:0]};
    return `RWS_WDOG_CNT_W'(BASE << sh);
  endfunction : rws_limit

  assign lim = rws_limit(w.sel);
  assign w.ovf = s.ovf;

  // count, clear on kick, pulse on overflow
  always_comb begin
    next_s = s;
    next_s.ovf = 1'b0;
    if (w.clr) begin
      next_s.cnt = '0;
    end else if (w.run && w.tick) begin
      if (s.cnt >= lim - 1'b1) begin
        next_s.cnt = '0;
        next_s.ovf = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_one_pulse;
    s.ovf ##1 !s.ovf;
  endsequence

  property p_wdog_clear;
    w.clr |=> s.cnt == '0 && !s.ovf;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not cleared");

  property p_wdog_ovf;
    (w.run && w.tick && !w.clr && s.cnt == lim - 1'b1) |=> s_one_pulse;
  endproperty
  a_wdog_ovf: assert property (p_wdog_ovf) else $error("watchdog overflow pulse wrong");
endmodule : rws_wdog

// *** bench/rws_core_model.sv ***
/*
  core model: issues one-cycle sfr reads and writes and notes each expected read byte.
  assumes clk is the system clock and the bench pops the notes.
*/
`timescale 1ns/1ps
module rws_core_model (
  input  wire logic clk,
  output logic [7:0] sfr_addr,
  output logic       sfr_wr,
  output logic       sfr_rd,
  output logic [7:0] sfr_wdata
);
  logic [7:0] exp_q[$];
  logic [7:0] adr_q[$];

  // idle bus at time zero
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
  end

  // write strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask : wr

  // read strobe; expected byte noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge clk);
    sfr_rd   <= 1'b0;
  endtask : rd

  // watchdog kick with the one valid pattern
  task automatic kick();
    wr(8'hB6, 8'h06);
  endtask : kick

  // service routine clears its flag by writing one
  task automatic clr_irq(input logic [7:0] m);
    wr(8'hB4, m);
  endtask : clr_irq
endmodule : rws_core_model

// *** bench/rws_tb_top.sv ***
/*
  self-checking bench: reset causes, pin filter, watchdog, sleep wake, brown-out and low-voltage.
  assumes the core model is compiled first; watchdog counts scaled down by RC_HZ.
*/
`timescale 1ns/1ps
module reset_watchdog_supply_supervisor_tb_top;
  localparam int RC_HZ = 256;
  localparam int BASE  = RC_HZ / 32;
  logic       CLK       = 1'b0;
  logic       RST_B     = 1'b0;
  logic       EXT_RST_B = 1'b1;
  logic       FRC       = 1'b0;
  logic       TICK      = 1'b0;
  logic       DSM       = 1'b0;
  logic [4:0] WAKE_SRC  = 5'h00;
  logic       OSC_LOCK  = 1'b1;
  logic       BOR_BELOW = 1'b0;
  logic       LV_BELOW  = 1'b0;
  logic       GIE       = 1'b0;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic       SFR_WR, SFR_RD, CPU_RST, SUP_IRQ, BOR_ON, LV_ON, MON_SEL;
  logic [1:0] BOR_SEL;
  logic [3:0] LV_SEL;
  logic       rd_q        = 1'b0;
  int         miscompares = 0;
  int         checks_done = 0;
  int         seed        = 32'hb57e;
  int         gap         = 0;
  int         ticks       = 0;
  int         t0, lim;

  rws_core_model core (.clk(CLK), .sfr_addr(SFR_ADDR), .sfr_wr(SFR_WR), .sfr_rd(SFR_RD),
                       .sfr_wdata(SFR_WDATA));
  rws_supervisor #(.RC_HZ(RC_HZ)) dut (.CLK(CLK), .RST_B(RST_B), .SFR_ADDR(SFR_ADDR),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .EXT_RST_B(EXT_RST_B),
    .WATCHDOG_FORCE_ENABLE_PIN(FRC), .WDOG_RC_TICK(TICK), .DEEP_SLEEP_MODE(DSM),
    .WAKE_SRC(WAKE_SRC), .OSC_LOCK(OSC_LOCK), .BROWNOUT_BELOW(BOR_BELOW),
    .LOW_VOLTAGE_BELOW(LV_BELOW), .SUPERVISOR_GLOBAL_IRQ_ENABLE(GIE), .SFR_RDATA(SFR_RDATA),
    .CPU_RST(CPU_RST), .SUP_IRQ(SUP_IRQ), .BROWNOUT_ON(BOR_ON), .BROWNOUT_THRESHOLD_SELECT(BOR_SEL),
    .LOW_VOLTAGE_ON(LV_ON), .LOW_VOLTAGE_THRESHOLD_SELECT(LV_SEL), .MONITOR_PIN_SEL(MON_SEL));

  // system clock
  always #5 CLK = ~CLK;

  // rc tick at random spacing of four to seven cycles
  always @(posedge CLK) begin
    TICK  <= (gap == 0);
    gap   <= (gap == 0) ? 3 + ($random(seed) & 3) : gap - 1;
    if (TICK) ticks <= ticks + 1;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // read watcher: oldest note against the byte returned
  always @(posedge CLK) rd_q <= SFR_RD;
  always @(negedge CLK) begin
    if (rd_q) check($sformatf("SFR_RDATA_%h", core.adr_q.pop_front()), SFR_RDATA, core.exp_q.pop_front());
  end

  // bounded wait for the core reset level
  task automatic wait_rst(input logic v, input int n);
    int i;
    @(negedge CLK);
    for (i = 0; i < n && CPU_RST !== v; i++) @(negedge CLK);
    check("CPU_RST", {7'd0, CPU_RST}, {7'd0, v});
    @(posedge CLK);
  endtask : wait_rst

  task automatic pin_low(input int n);
    @(posedge CLK);
    EXT_RST_B <= 1'b0;
    repeat (n) @(posedge CLK);
    EXT_RST_B <= 1'b1;
  endtask : pin_low

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // hang guard
  initial begin
    repeat (40000) @(posedge CLK);
    miscompares++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge CLK);
    check("LV_PINS", {LV_ON, BOR_ON, MON_SEL, 1'b0, LV_SEL}, 8'hC0);
    RST_B <= 1'b1;
    core.rd(8'hB7, 8'h80);
    core.rd(8'hB7, 8'h00);
    core.rd(8'hBC, 8'h11);
    core.rd(8'hBF, 8'h27);
    core.rd(8'hB6, 8'h80);
    core.rd(8'h00, 8'h00);
    @(negedge CLK);
    check("BOR_SEL", {6'd0, BOR_SEL}, 8'h00);
    // pin filter: short pulse ignored, long pulse resets
    core.wr(8'hBD, 8'h0F);
    pin_low(150);
    repeat (20) @(negedge CLK);
    check("CPU_RST", {7'd0, CPU_RST}, 8'h00);
    pin_low(250);
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 60);
    core.rd(8'hB7, 8'h40);
    core.rd(8'hBD, 8'h00);
    // every timeout code, measured in rc ticks
    for (int c = 0; c < 8; c++) begin
      lim = c[2] ? BASE << c[1:0] : (BASE * 16) << c[1:0];
      core.wr(8'hBD, {c[2:0], 5'h10});
      t0 = ticks;
      wait_rst(1'b1, lim * 8 + 40);
      check("WDOG_TICKS", {7'd0, (ticks - t0 >= lim - 2) && (ticks - t0 <= lim + 2)}, 8'h01);
      wait_rst(1'b0, 40);
      core.rd(8'hB7, 8'h20);
    end
    // kicks hold off the reset, other patterns do not
    core.wr(8'hBD, 8'h90);
    repeat (10) begin
      repeat (18) @(posedge CLK);
      core.kick();
    end
    @(negedge CLK);
    check("CPU_RST", {7'd0, CPU_RST}, 8'h00);
    repeat (6) begin
      repeat (18) @(posedge CLK);
      core.wr(8'hB6, 8'h0E);
    end
    core.rd(8'hB7, 8'h20);
    // force pin overrides a clear soft enable
    FRC <= 1'b1;
    wait_rst(1'b1, 128 * 8 + 40);
    FRC <= 1'b0;
    wait_rst(1'b0, 40);
    core.rd(8'hB7, 8'h20);
    core.wr(8'hBD, 8'h80);
    repeat (300) @(negedge CLK);
    check("CPU_RST", {7'd0, CPU_RST}, 8'h00);
    // every WAKE_SRC bit; watchdog halted in sleep without keep-alive
    for (int s = 0; s < 5; s++) begin
      core.wr(8'hBD, 8'h90);
      DSM <= 1'b1;
      repeat (80) @(negedge CLK);
      check("CPU_RST", {7'd0, CPU_RST}, 8'h00);
      @(posedge CLK);
      WAKE_SRC <= 5'h01 << s;
      wait_rst(1'b1, 8);
      DSM      <= 1'b0;
      WAKE_SRC <= 5'h00;
      wait_rst(1'b0, 40);
      core.rd(8'hB7, 8'h08);
    end
    // keep-alive: watchdog overflow wakes from sleep
    core.wr(8'hBC, 8'h13);
    core.wr(8'hBD, 8'h90);
    DSM <= 1'b1;
    wait_rst(1'b1, BASE * 8 + 20);
    DSM <= 1'b0;
    wait_rst(1'b0, 40);
    core.rd(8'hB7, 8'h28);
    // brown-out reset mode, held while below
    BOR_BELOW <= 1'b1;
    wait_rst(1'b1, 8);
    core.rd(8'hB6, 8'hC0);
    BOR_BELOW <= 1'b0;
    wait_rst(1'b0, 40);
    core.rd(8'hB7, 8'h10);
    core.rd(8'hB6, 8'h80);
    // brown-out left on in sleep wakes with a reset, no interrupt
    core.wr(8'hBC, 8'h31);
    DSM <= 1'b1;
    repeat (4) @(posedge CLK);
    BOR_BELOW <= 1'b1;
    wait_rst(1'b1, 8);
    DSM       <= 1'b0;
    BOR_BELOW <= 1'b0;
    wait_rst(1'b0, 40);
    core.rd(8'hB7, 8'h18);
    // threshold codes, then interrupt mode
    for (int t = 0; t < 4; t++) begin
      core.wr(8'hBC, {4'h0, t[1:0], 2'b00});
      repeat (2) @(negedge CLK);
      check("BOR_SEL", {6'd0, BOR_SEL}, t[7:0]);
    end
    core.rd(8'hBC, 8'h0D);
    core.wr(8'hAC, 8'h03);
    GIE       <= 1'b1;
    BOR_BELOW <= 1'b1;
    repeat (5) @(negedge CLK);
    check("SUP_IRQ", {7'd0, SUP_IRQ}, 8'h01);
    core.rd(8'hB4, 8'h01);
    core.clr_irq(8'h01);
    core.rd(8'hB4, 8'h00);
    BOR_BELOW <= 1'b0;
    repeat (5) @(negedge CLK);
    core.rd(8'hB4, 8'h01);
    core.clr_irq(8'h01);
    GIE       <= 1'b0;
    BOR_BELOW <= 1'b1;
    repeat (5) @(negedge CLK);
    core.rd(8'hB4, 8'h00);
    GIE      <= 1'b1;
    LV_BELOW <= 1'b1;
    repeat (5) @(negedge CLK);
    core.rd(8'hB4, 8'h02);
    core.rd(8'hB6, 8'hE0);
    core.clr_irq(8'h02);
    core.rd(8'hB4, 8'h00);
    @(negedge CLK);
    check("SUP_IRQ", {7'd0, SUP_IRQ}, 8'h00);
    // detector power-down and monitor pin selection
    core.wr(8'hB5, 8'hC5);
    core.wr(8'hBF, 8'h98);
    core.rd(8'hBF, 8'h18);
    core.rd(8'hB6, 8'h80);
    core.rd(8'hB5, 8'hC0);
    check("LV_PINS", {LV_ON, BOR_ON, MON_SEL, 1'b0, LV_SEL}, 8'h0C);
    core.wr(8'hBF, 8'h00);
    repeat (2) @(negedge CLK);
    check("LV_PINS", {LV_ON, BOR_ON, MON_SEL, 1'b0, LV_SEL}, 8'hEC);
    core.wr(8'hB5, 8'hB0);
    repeat (2) @(negedge CLK);
    check("LV_PINS", {LV_ON, BOR_ON, MON_SEL, 1'b0, LV_SEL}, 8'hCB);
    // power-on clears a pending pin cause
    @(posedge CLK);
    BOR_BELOW <= 1'b0;
    LV_BELOW  <= 1'b0;
    pin_low(250);
    wait_rst(1'b0, 60);
    RST_B <= 1'b0;
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    core.rd(8'hB7, 8'h80);
    repeat (4) @(posedge CLK);
    conclude();
  end
endmodule : reset_watchdog_supply_supervisor_tb_top
